// *** core/cbt_timer_fault.sv ***
`timescale 1ns/1ps
module cbt_timer_fault
  import cbt_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEFAULT
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Wishbone slave
  input  wire logic              wbCyc,
  input  wire logic              wbStb,
  input  wire logic              wbWe,
  input  wire logic [ADR_W-1:0]  wbAdr,
  input  wire logic [3:0]        wbSel,
  input  wire logic [DAT_W-1:0]  wbDatI,
  output logic      [DAT_W-1:0]  wbDatO,
  output logic                   wbAck,
  // Balancing switches
  input  wire logic [NUM_CH-1:0] switchObserved,
  output logic      [NUM_CH-1:0] balanceOn,
  // Interrupt
  output logic                   irq
);

  // Bus decode
  logic                 access;
  logic                 wrAcc;
  logic                 rdAcc;
  logic [IDX_W-1:0]     regIdx;
  logic [IDX_W-1:0]     chOffset;
  logic                 chHit;
  logic [DAT_W-1:0]     wrMask;
  logic [DAT_W-1:0]     wrData;

  // State
  logic [1:0]           ctrl;
  logic [NUM_CH-1:0]    chEn;
  logic [NUM_CH-1:0]    fault;
  logic [IRQ_W-1:0]     irqStat;
  logic [IRQ_W-1:0]     irqEn;
  logic [TIMER_W-1:0]   timer [NUM_CH];
  logic [TICK_CNT_W-1:0] tickCnt;
  logic                 tick;

  // Next values
  logic [1:0]           next_ctrl;
  logic [NUM_CH-1:0]    next_chEn;
  logic [NUM_CH-1:0]    next_fault;
  logic [IRQ_W-1:0]     next_irqStat;
  logic [IRQ_W-1:0]     next_irqEn;
  logic [TIMER_W-1:0]   next_timer [NUM_CH];
  logic [TICK_CNT_W-1:0] next_tickCnt;
  logic [DAT_W-1:0]     next_wbDatO;
  logic                 next_wbAck;
  logic [NUM_CH-1:0]    next_balanceOn;
  logic                 next_irq;
  logic [NUM_CH-1:0]    readClr;
  logic [NUM_CH-1:0]    timer_elapsed_value;
  logic [NUM_CH-1:0]    detect;
  logic [DAT_W-1:0]     rdData;

  // One access per request; ack in the following cycle drops the request
  assign access   = wbCyc & wbStb & ~wbAck;
  assign wrAcc    = access & wbWe;
  assign rdAcc    = access & ~wbWe;
  assign regIdx   = wbAdr[ADR_W-1:2];
  assign chOffset = regIdx - IDX_CH0_TIMER;
  assign chHit    = (regIdx >= IDX_CH0_TIMER) && (chOffset < IDX_W'(NUM_CH));
  assign wrMask   = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}}, {8{wbSel[0]}}};
  assign wrData   = wbDatI & wrMask;

  // Prescaler; the count is a parameter so simulation can shorten the 10 s unit
  always_comb begin
    if (tickCnt == TICK_CNT_W'(TICK_CYCLES - 1)) begin
      next_tickCnt = '0;
    end else begin
      next_tickCnt = tickCnt + 1'b1;
    end
  end

  assign tick = (tickCnt == TICK_CNT_W'(TICK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      tickCnt <= '0;
    end else begin
      tickCnt <= next_tickCnt;
    end
  end

  // Per-channel countdown timers
  for (genvar i = 0; i < NUM_CH; i++) begin : gChannel
    logic run;
    logic chWrite;
    assign run     = tick & ctrl[CTRL_GLOBAL_BIT] & ctrl[CTRL_TIMER_BIT] & chEn[i];
    assign chWrite = wrAcc && chHit && (chOffset == IDX_W'(i));

    // Writes beat the tick so a reload never loses one count to a racing decrement
    always_comb begin
      next_timer[i] = timer[i];
      timer_elapsed_value[i]    = 1'b0;
      if (wrAcc && regIdx == IDX_ALL_LOAD) begin
        next_timer[i] = (timer[i] & ~wrMask[TIMER_W-1:0]) | wrData[TIMER_W-1:0];
      end else if (chWrite) begin
        next_timer[i] = (timer[i] & ~wrMask[TIMER_W-1:0]) | wrData[TIMER_W-1:0];
      end else if (run && timer[i] != TIMER_ELAPSED_VALUE) begin
        next_timer[i] = timer[i] - 1'b1;
        timer_elapsed_value[i]    = (timer[i] == TIMER_W'(1));
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        timer[i] <= TIMER_ELAPSED_VALUE;
      end else begin
        timer[i] <= next_timer[i];
      end
    end

    // Switch is expected on only while enabled and time remains
    assign next_balanceOn[i] = ctrl[CTRL_GLOBAL_BIT] & chEn[i]
                             & (next_timer[i] != TIMER_ELAPSED_VALUE);
    assign detect[i]         = (switchObserved[i] != balanceOn[i]);
  end

  // Read mux; narrow registers sit in the low bits, the rest reads zero
  always_comb begin
    rdData  = '0;
    readClr = '0;
    if (chHit) begin
      rdData[TIMER_W-1:0] = timer[chOffset[4:0]];
    end else begin
      case (regIdx)
        IDX_CTRL: begin
          rdData[1:0] = ctrl;
        end
        IDX_CH_EN: begin
          rdData[NUM_CH-1:0] = chEn;
        end
        IDX_IRQ_STAT: begin
          rdData[IRQ_W-1:0] = irqStat;
        end
        IDX_IRQ_EN: begin
          rdData[IRQ_W-1:0] = irqEn;
        end
        IDX_FAULT_LOW: begin
          rdData[FAULT_LOW_CHANNELS-1:0] = fault[FAULT_LOW_CHANNELS-1:0];
          readClr[FAULT_LOW_CHANNELS-1:0] = fault[FAULT_LOW_CHANNELS-1:0];
        end
        IDX_FAULT_HIGH: begin
          rdData[1:0] = fault[NUM_CH-1:FAULT_LOW_CHANNELS];
          readClr[NUM_CH-1:FAULT_LOW_CHANNELS] = fault[NUM_CH-1:FAULT_LOW_CHANNELS];
        end
        default: begin
          rdData = '0;
        end
      endcase
    end
  end

  // Control, enables, faults and interrupt state
  always_comb begin
    next_ctrl    = ctrl;
    next_chEn    = chEn;
    next_irqEn   = irqEn;
    next_irqStat = irqStat;
    if (wrAcc && regIdx == IDX_CTRL) begin
      next_ctrl = (ctrl & ~wrMask[1:0]) | wrData[1:0];
    end
    if (wrAcc && regIdx == IDX_CH_EN) begin
      next_chEn = (chEn & ~wrMask[NUM_CH-1:0]) | wrData[NUM_CH-1:0];
    end
    if (wrAcc && regIdx == IDX_IRQ_EN) begin
      next_irqEn = (irqEn & ~wrMask[IRQ_W-1:0]) | wrData[IRQ_W-1:0];
    end
    if (wrAcc && regIdx == IDX_IRQ_CLR) begin
      next_irqStat = irqStat & ~wrData[IRQ_W-1:0];
    end
    // A new event in the clearing cycle survives the clear
    next_irqStat[NUM_CH-1:0]    = next_irqStat[NUM_CH-1:0] | timer_elapsed_value;
    next_irqStat[IRQ_FAULT_BIT] = next_irqStat[IRQ_FAULT_BIT] | (|(detect & ~fault));
    // Only returned flags clear; a fault seen in the read cycle stays set
    next_fault = (fault & ~(rdAcc ? readClr : '0)) | detect;
    next_irq   = |(next_irqStat & next_irqEn);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl      <= CTRL_RESET;
      chEn      <= CH_EN_RESET;
      fault     <= {NUM_CH{NO_FAULT_VALUE}};
      irqStat   <= IRQ_RESET;
      irqEn     <= IRQ_RESET;
      irq       <= 1'b0;
      balanceOn <= '0;
    end else begin
      ctrl      <= next_ctrl;
      chEn      <= next_chEn;
      fault     <= next_fault;
      irqStat   <= next_irqStat;
      irqEn     <= next_irqEn;
      irq       <= next_irq;
      balanceOn <= next_balanceOn;
    end
  end

  // Bus answer: ack one cycle after the request, unmapped reads give zero
  always_comb begin
    next_wbAck  = access;
    next_wbDatO = rdAcc ? rdData : '0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wbAck  <= 1'b0;
      wbDatO <= '0;
    end else begin
      wbAck  <= next_wbAck;
      wbDatO <= next_wbDatO;
    end
  end

endmodule

// *** core/cbt_pkg.sv ***
package cbt_pkg;

  // Sizes
  localparam int NUM_CH  = 18;
  localparam int TIMER_W = 14;
  localparam int REG_W   = 16;
  localparam int DAT_W   = 32;
  localparam int ADR_W   = 16;
  localparam int IDX_W   = 14;
  localparam int IRQ_W   = 19;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL       = 14'h1000;
  localparam logic [IDX_W-1:0] IDX_CH_EN      = 14'h1001;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT   = 14'h1002;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR    = 14'h1003;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN     = 14'h1004;
  localparam logic [IDX_W-1:0] IDX_FAULT_LOW  = 14'h1012;
  localparam logic [IDX_W-1:0] IDX_FAULT_HIGH = 14'h1013;
  localparam logic [IDX_W-1:0] IDX_ALL_LOAD   = 14'h101F;
  localparam logic [IDX_W-1:0] IDX_CH0_TIMER  = 14'h1020;

  // Field positions
  localparam int CTRL_GLOBAL_BIT       = 0;
  localparam int CTRL_TIMER_BIT        = 1;
  localparam int FAULT_LOW_CHANNELS    = 16;
  localparam int IRQ_FAULT_BIT         = 18;

  // Reset values and encodings
  localparam logic [TIMER_W-1:0] TIMER_ELAPSED_VALUE = 14'h0000;
  localparam logic [TIMER_W-1:0] TIMER_MAX_VALUE     = 14'h3FFF;
  localparam logic               NO_FAULT_VALUE      = 1'b0;
  localparam logic [1:0]         CTRL_RESET          = 2'h0;
  localparam logic [NUM_CH-1:0]  CH_EN_RESET         = 18'h00000;
  localparam logic [IRQ_W-1:0]   IRQ_RESET           = 19'h00000;

  // Timing: one timer unit in seconds, clock rate in hertz
  localparam int TICK_PERIOD_S       = 10;
  localparam int CLK_HZ              = 100_000_000;
  localparam int TICK_CYCLES_DEFAULT = TICK_PERIOD_S * CLK_HZ;
  localparam int TICK_CNT_W          = 30;

endpackage

// *** verification/cbt_chk.sv ***
`timescale 1ns/1ps
module cbt_chk
  import cbt_pkg::*;
(
  // Clock and bus
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              wbCyc,
  input wire logic              wbStb,
  input wire logic              wbWe,
  input wire logic [ADR_W-1:0]  wbAdr,
  input wire logic [3:0]        wbSel,
  input wire logic [DAT_W-1:0]  wbDatI,
  input wire logic [DAT_W-1:0]  wbDatO,
  input wire logic              wbAck,
  // Switches and interrupt
  input wire logic [NUM_CH-1:0] switchObserved,
  input wire logic [NUM_CH-1:0] balanceOn,
  input wire logic              irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Master holds address and data through ack, so they describe the answered access
  wire logic [IDX_W-1:0] idx = wbAdr[15:2];
  wire logic             wrZero = wbAck && wbWe && wbSel[1:0] == 2'h3 && wbDatI[13:0] == 14'h0000;

  ack_next_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck) else $error("ack late");
  ack_pulse_a: assert property (wbAck |=> !wbAck) else $error("ack held");
  dat_idle_a: assert property (!wbAck |-> wbDatO == 32'h0) else $error("data without ack");
  high_rsv_a: assert property (wbAck && idx == IDX_FAULT_HIGH |-> wbDatO[31:2] == 30'h0)
    else $error("fault high reserved set");
  tmr_rsv_a: assert property (wbAck && idx >= IDX_CH0_TIMER && idx < IDX_CH0_TIMER + 14'h0012
    |-> wbDatO[31:14] == 18'h0) else $error("timer reserved set");
  all_rd_a: assert property (wbAck && !wbWe && idx == IDX_ALL_LOAD |-> wbDatO == 32'h0) else $error("load readable");
  zero_stop_a: assert property (wrZero && idx == IDX_CH0_TIMER |-> !balanceOn[0])
    else $error("zero timer balancing");
  all_zero_a: assert property (wrZero && idx == IDX_ALL_LOAD |-> balanceOn == 18'h0)
    else $error("broadcast zero balancing");
  rst_clear_a: assert property ($past(rst) |-> balanceOn == 18'h0 && !irq)
    else $error("outputs after reset");

  // Main scenarios
  cover property (irq);
  cover property (wbAck && idx == IDX_ALL_LOAD);
  cover property ($fell(balanceOn[0]));
endmodule

bind cbt_timer_fault cbt_chk u_chk (.clk, .rst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatI, .wbDatO,
  .wbAck, .switchObserved, .balanceOn, .irq);

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench
  import cbt_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              wbCyc = 1'b0;
  logic              wbStb = 1'b0;
  logic              wbWe = 1'b0;
  logic [ADR_W-1:0]  wbAdr = 16'h0000;
  logic [3:0]        wbSel = 4'hF;
  logic [DAT_W-1:0]  wbDatI = 32'h0;
  logic [DAT_W-1:0]  wbDatO;
  logic              wbAck;
  logic [NUM_CH-1:0] switchObserved = 18'h0;
  logic [NUM_CH-1:0] balanceOn;
  logic              irq;
  logic [31:0]       q;
  int                fails = 0;
  int                total_checks = 0;
  int                cyc = 0;

  // Short tick keeps countdowns within a few hundred cycles
  cbt_timer_fault #(.TICK_CYCLES(20)) DUT (.clk, .rst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatI,
    .wbDatO, .wbAck, .switchObserved, .balanceOn, .irq);

  // Clock
  always #5 clk = ~clk;
  // Watchdog against a missing ack
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end

  task end_sim();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled, then release
  task wb(logic w, logic [IDX_W-1:0] i, logic [31:0] d);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= {i, 2'h0};
    wbDatI <= d;
    do @(posedge clk); while (wbAck !== 1'b1);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task rdc(string n, logic [IDX_W-1:0] i, logic [31:0] e);
    wb(1'b0, i, 32'h0);
    chk(n, e, q);
  endtask

  // Switch pulse on the channels set in m for two cycles
  task pulse(logic [NUM_CH-1:0] m);
    @(posedge clk);
    switchObserved <= m;
    repeat (2) @(posedge clk);
    switchObserved <= 18'h0;
  endtask

  task t_reset();
    rdc("faultLo", IDX_FAULT_LOW, 32'h0);
    rdc("tmr17", IDX_CH0_TIMER + 14'h0011, 32'h0);
    rdc("unmapped", 14'h0000, 32'h0);
  endtask

  // Clear on read, bit placement and the fault interrupt raised, cleared, masked
  task t_fault();
    wb(1'b1, IDX_IRQ_EN, 32'h40000);
    pulse(18'h10008);
    rdc("faultLo", IDX_FAULT_LOW, 32'h8);
    rdc("faultLo2", IDX_FAULT_LOW, 32'h0);
    rdc("faultHi", IDX_FAULT_HIGH, 32'h1);
    rdc("faultHi2", IDX_FAULT_HIGH, 32'h0);
    chk("irqSet", 32'h1, irq);
    wb(1'b1, IDX_IRQ_CLR, 32'h40000);
    repeat (2) @(posedge clk);
    chk("irqClr", 32'h0, irq);
    wb(1'b1, IDX_IRQ_EN, 32'h0);
    pulse(18'h20000);
    repeat (2) @(posedge clk);
    chk("irqMask", 32'h0, irq);
    rdc("faultHi3", IDX_FAULT_HIGH, 32'h2);
  endtask

  task t_bcast();
    wb(1'b1, IDX_ALL_LOAD, 32'hFFFF);
    rdc("tmr0", IDX_CH0_TIMER, 32'h3FFF);
    rdc("tmr17", IDX_CH0_TIMER + 14'h0011, 32'h3FFF);
    rdc("allRd", IDX_ALL_LOAD, 32'h0);
    wb(1'b1, IDX_ALL_LOAD, 32'h0);
    rdc("tmr9", IDX_CH0_TIMER + 14'h0009, 32'h0);
  endtask

  // Channels 0 and 1 enabled, channel 2 loaded but idle
  task t_count();
    wb(1'b1, IDX_CTRL, 32'h3);
    wb(1'b1, IDX_CH_EN, 32'h3);
    wb(1'b1, IDX_CH0_TIMER, 32'h2);
    wb(1'b1, IDX_CH0_TIMER + 14'h0001, 32'h3FFF);
    wb(1'b1, IDX_CH0_TIMER + 14'h0002, 32'h5);
    repeat (80) @(posedge clk);
    chk("balOn", 32'h2, balanceOn);
    rdc("tmr0", IDX_CH0_TIMER, 32'h0);
    rdc("tmr2", IDX_CH0_TIMER + 14'h0002, 32'h5);
    rdc("irqStat", IDX_IRQ_STAT, 32'h40001);
    rdc("faultLo", IDX_FAULT_LOW, 32'h3);
    wb(1'b1, IDX_ALL_LOAD, 32'h0);
    chk("balOff", 32'h0, balanceOn);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fault();
    t_bcast();
    t_count();
    end_sim();
  end
endmodule
